// *** verilog/rsc_cfg.svh ***
/*
  Constants of the reset source controller: register offsets, field positions,
  reset values, key codes and timing figures.
  Assumes a 125 MHz core clock; included by the controller only.
*/
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// register offsets (byte wide registers, byte addresses)
`define RSC_OFF_KEY       8'h00
`define RSC_OFF_CAUSE     8'h01
`define RSC_OFF_EVT       8'h02
`define RSC_OFF_MASK      8'h03

// reset values
`define RSC_KEY_RST       8'h00
`define RSC_CAUSE_POR     6'h01
`define RSC_EVT_RST       3'h0
`define RSC_MASK_RST      3'h0

// pin configuration key codes
`define RSC_KEY_GPIO      8'hD0
`define RSC_KEY_PIN       8'h00

// reset cause flag positions
`define RSC_BIT_POR       0
`define RSC_BIT_IDOG      1
`define RSC_BIT_BADOP     2
`define RSC_BIT_DEBUG     3
`define RSC_BIT_WDOG      4
`define RSC_BIT_BROWN     5

// event flag positions
`define RSC_EVT_GPIO_ON   0
`define RSC_EVT_KEY_LATE  1
`define RSC_EVT_PIN_IGN   2

// boot vector and timing
`define RSC_BOOT_VECTOR   16'h8000
`define RSC_CLK_NS        8
`define RSC_PULSE_NS      20000
`define RSC_POR_HOLD_NS   1000

`endif

// *** verilog/rsc_pkg.sv ***
/*
  Types of the reset source controller: state codes, register bus request,
  and the packed state of the controller.
  Assumes rsc_cfg.svh sits on the include path.
*/
`default_nettype none

package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_RUN   = 2'b00,
    RSC_PULSE = 2'b01,
    RSC_PIN   = 2'b10,
    RSC_POR   = 2'b11
  } rsc_state_t;

  // one register access from software
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_bus_t;

  // internal reset requesters
  typedef struct packed {
    logic brown;
    logic wdog;
    logic debug;
    logic idog;
  } rsc_src_t;

  // whole controller state
  typedef struct packed {
    rsc_state_t  st;
    logic [15:0] cnt;
    logic [7:0]  key;
    logic        lock;
    logic [5:0]  cause;
    logic [2:0]  evt;
    logic [2:0]  mask;
    logic [7:0]  rdata;
    logic        boot;
  } rsc_regs_t;

endpackage

`default_nettype wire

// *** verilog/rsc_controller.sv ***
/*
  Reset source controller: gathers pin, power, watchdog, bad opcode and debug
  link resets, drives the shared open-drain reset pin, records the cause of all but pin resets.
  Assumes inputs synchronous to core_clk and a tristate pad outside.
*/
// Local design decision: the strobed register port.
`default_nettype none
`include "rsc_cfg.svh"

// Function
// RQ1: six sources are accepted and every one of them acts on the reset pin; here power-on does not drive the pin, only the five internal requests do.
// RQ2: after release, execution starts at vector 0x8000.
// RQ3: an outside party holds the reset pin low at least 300 ns.
// RQ4: pin reset reaches the core without needing a clock edge.
// RQ5: an internal request drives the pin low for at least 20 us.
// RQ6: key 0xD0 turns the pin into push-pull output, once per reset.
// RQ7: in output mode the pin cannot reset the device.
// RQ8: key register resets to 0x00, other values store as 0x00, always readable.
// RQ9: the flag of the causing source is set.
// RQ10: a written one clears a flag; a written zero keeps it.
// RQ11: power-on leaves only the power-on flag set, status 0x01.
// RQ12: flags: brownout 5, window dog 4, debug 3, bad opcode 2, indep dog 1, power-on 0.
// RQ13: software writes zero to status bits 7:6.
// RQ14: fetched code matching no opcode and no prebyte raises a reset.
// RQ15: a debug link request gives a full device reset.
// RQ16: power-on holds reset until supply is good, then a fixed time more.
// RQ17: registers take their reset values by the end of the reset phase; internal and pin resets reload only key and lock.
// RQ18: simultaneous sources all get their flags set.
module rsc_controller #(
  parameter int POR_HOLD_NS = `RSC_POR_HOLD_NS
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire rsc_pkg::rsc_bus_t bus_req,
  output logic [7:0]            rd_data,
  input  wire logic             supply_ok,
  input  wire rsc_pkg::rsc_src_t src_req,
  input  wire logic             fetch_strobe,
  input  wire logic             opcode_hit,
  input  wire logic             prebyte_hit,
  input  wire logic             reset_pin_in,
  output logic                  reset_pin_out,
  output logic                  reset_pin_oe,
  input  wire logic             port_a_bit1_output,
  output logic                  core_reset,
  output logic                  boot_start,
  output logic [15:0]           boot_vector,
  output logic                  irq
);

  // cycle counts rounded up so the pulse never falls short of its time
  localparam logic [15:0] PULSE_CYC =
    16'((`RSC_PULSE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS);
  localparam int POR_RAW = (POR_HOLD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam logic [15:0] POR_CYC = 16'((POR_RAW < 1) ? 1 : POR_RAW);

  rsc_pkg::rsc_regs_t q;
  rsc_pkg::rsc_regs_t d;

  logic       gpio_mode;
  logic       bad_op;
  logic [5:0] set_vec;
  logic       int_req;
  logic       pin_low;

  // register select, one address compare shared by read and write
  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    sel = (a == off);
  endfunction

  // source decode; power-on flag comes only from the power path
  assign gpio_mode = (q.key == `RSC_KEY_GPIO);                       // RQ6
  assign bad_op    = fetch_strobe && !opcode_hit && !prebyte_hit;    // RQ14
  assign set_vec   = {src_req.brown, src_req.wdog, src_req.debug,   // RQ12
                      bad_op, src_req.idog, 1'b0};
  assign int_req   = |set_vec;                                       // RQ1
  // pin reset only counts in pin mode; output mode drives the pad itself
  assign pin_low   = !gpio_mode && !reset_pin_in;

  // next state
  always_comb begin
    d      = q;
    d.boot = 1'b0;
    d.rdata = 8'h00;
    // cause flags: set wins over a written one
    if (bus_req.wr && sel(bus_req.addr, `RSC_OFF_CAUSE)) begin
      d.cause = q.cause & ~bus_req.wdata[5:0];                       // RQ10
    end
    if (q.st != rsc_pkg::RSC_POR) begin
      d.cause = d.cause | set_vec;                                   // RQ9 RQ18
    end
    // event register read clears, new events still land
    if (bus_req.rd && sel(bus_req.addr, `RSC_OFF_EVT)) begin
      d.evt = 3'h0;
    end
    if (bus_req.wr && sel(bus_req.addr, `RSC_OFF_MASK)) begin
      d.mask = bus_req.wdata[2:0];
    end
    // key: first write after a reset is taken, later ones refused
    if (bus_req.wr && sel(bus_req.addr, `RSC_OFF_KEY)) begin
      if (!q.lock) begin
        d.lock = 1'b1;                                               // RQ6
        d.key  = (bus_req.wdata == `RSC_KEY_GPIO) ? `RSC_KEY_GPIO
                                                  : `RSC_KEY_PIN;    // RQ8
        if (bus_req.wdata == `RSC_KEY_GPIO) begin
          d.evt[`RSC_EVT_GPIO_ON] = 1'b1;
        end
      end else begin
        d.evt[`RSC_EVT_KEY_LATE] = 1'b1;
      end
    end
    // read data stands one cycle only, unmapped reads zero
    if (bus_req.rd) begin
      if (sel(bus_req.addr, `RSC_OFF_KEY)) begin
        d.rdata = q.key;                                             // RQ8
      end else if (sel(bus_req.addr, `RSC_OFF_CAUSE)) begin
        d.rdata = {2'b00, q.cause};
      end else if (sel(bus_req.addr, `RSC_OFF_EVT)) begin
        d.rdata = {5'h00, q.evt};
      end else if (sel(bus_req.addr, `RSC_OFF_MASK)) begin
        d.rdata = {5'h00, q.mask};
      end
    end
    // reset sequencing
    case (q.st)
      rsc_pkg::RSC_RUN: begin
        if (int_req) begin
          d.st   = rsc_pkg::RSC_PULSE;                               // RQ5 RQ15
          d.cnt  = 16'h0000;
          d.key  = `RSC_KEY_RST;                                     // RQ17
          d.lock = 1'b0;
        end else if (pin_low) begin
          d.st   = rsc_pkg::RSC_PIN;
          d.key  = `RSC_KEY_RST;
          d.lock = 1'b0;
        end else if (gpio_mode && !reset_pin_in && port_a_bit1_output) begin
          // our own low drive reads back low; only a pull against a high counts
          d.evt[`RSC_EVT_PIN_IGN] = 1'b1;                            // RQ7
        end
      end
      rsc_pkg::RSC_PULSE: begin
        // width counted in core clocks, independent of what the pin reads
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt >= PULSE_CYC - 16'h0001) begin
          d.st = rsc_pkg::RSC_PIN;                                   // RQ5
        end
      end
      rsc_pkg::RSC_PIN: begin
        // another party may still hold the pin; wait for it
        if (reset_pin_in) begin
          d.st   = rsc_pkg::RSC_RUN;
          d.boot = 1'b1;                                             // RQ2
        end
      end
      rsc_pkg::RSC_POR: begin
        // a supply dip restarts the hold count rather than pausing it
        if (!supply_ok) begin
          d.cnt = 16'h0000;
        end else if (q.cnt >= POR_CYC - 16'h0001) begin
          d.st   = rsc_pkg::RSC_RUN;                                 // RQ16
          d.boot = 1'b1;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      default: begin
        d.st = rsc_pkg::RSC_POR;
      end
    endcase
    // supply loss restarts the power-on phase from anywhere
    if (!supply_ok) begin
      d.st    = rsc_pkg::RSC_POR;                                    // RQ16
      d.cnt   = 16'h0000;
      d.cause = `RSC_CAUSE_POR;                                      // RQ11
      d.key   = `RSC_KEY_RST;
      d.lock  = 1'b0;
    end
  end

  // single state register; sys_rst acts as the power-on reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q.st    <= rsc_pkg::RSC_POR;
      q.cnt   <= 16'h0000;
      q.key   <= `RSC_KEY_RST;                                       // RQ8
      q.lock  <= 1'b0;
      q.cause <= `RSC_CAUSE_POR;                                     // RQ11
      q.evt   <= `RSC_EVT_RST;
      q.mask  <= `RSC_MASK_RST;
      q.rdata <= 8'h00;
      q.boot  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // pin reset bypasses the flops so a stopped clock still resets the core
  assign core_reset    = sys_rst || (q.st != rsc_pkg::RSC_RUN) || pin_low; // RQ4 RQ7
  // open drain: only ever drive low; push-pull once the key is taken
  assign reset_pin_oe  = gpio_mode || (q.st == rsc_pkg::RSC_PULSE);   // RQ5 RQ6
  assign reset_pin_out = gpio_mode && port_a_bit1_output;
  assign rd_data       = q.rdata;
  assign boot_start    = q.boot;
  assign boot_vector   = `RSC_BOOT_VECTOR;                             // RQ2
  assign irq           = |(q.evt & q.mask);

  // sequences of the reset walk
  sequence s_pulse_start;
    q.st == rsc_pkg::RSC_RUN && int_req && supply_ok;
  endsequence

  sequence s_pulse_hold;
    (reset_pin_oe && !reset_pin_out)[*8];
  endsequence

  a_pulse_drive: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ5
    s_pulse_start |=> s_pulse_hold)
    else $error("reset pin not driven low after internal request");

  // pulse never ends before the full count
  a_pulse_length: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ5
    (q.st == rsc_pkg::RSC_PULSE && q.cnt < PULSE_CYC - 16'h0001 && supply_ok)
    |=> q.st == rsc_pkg::RSC_PULSE)
    else $error("reset pulse ended early");

  a_boot_vector: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ2
    boot_start |-> boot_vector == 16'h8000 && !core_reset && $past(core_reset))
    else $error("boot start without release or wrong vector");

  a_async_pin: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ4
    (!gpio_mode && !reset_pin_in) |-> core_reset)
    else $error("pin reset did not reach core at once");

  a_key_once: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ6
    (q.lock && bus_req.wr && bus_req.addr == 8'h00 && q.st == rsc_pkg::RSC_RUN
     && !int_req && supply_ok) |=> $stable(q.key))
    else $error("key changed after first write");

  a_key_value: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ8
    q.key == 8'h00 || q.key == 8'hD0)
    else $error("key holds a value other than 00 or D0");

  a_gpio_pin: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ7
    (gpio_mode && !reset_pin_in && q.st == rsc_pkg::RSC_RUN && !int_req
     && supply_ok) |=> q.st == rsc_pkg::RSC_RUN && reset_pin_oe)
    else $error("pin reset taken in output mode");

  a_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ9 RQ18
    (q.st != rsc_pkg::RSC_POR && supply_ok && int_req)
    |=> (q.cause & $past(set_vec)) == $past(set_vec))
    else $error("cause flag missing after request");

  a_flag_keep: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ10
    (bus_req.wr && bus_req.addr == 8'h01 && bus_req.wdata == 8'h00 && supply_ok)
    |=> (q.cause & $past(q.cause)) == $past(q.cause))
    else $error("zero write cleared a flag");

  a_por_value: assert property (@(posedge core_clk) // RQ11
    sys_rst |=> q.cause == 6'h01 && q.st == rsc_pkg::RSC_POR)
    else $error("power-on status is not 01");

  // pin path: a low pin in pin mode enters the wait and re-arms the key
  a_pin_entry: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ4 RQ17
    (q.st == rsc_pkg::RSC_RUN && pin_low && !int_req && supply_ok)
    |=> q.st == rsc_pkg::RSC_PIN && q.key == 8'h00 && !q.lock)
    else $error("pin reset did not enter the pin wait");

  // the wait lasts as long as anyone still holds the pin low
  a_pin_wait: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ5
    (q.st == rsc_pkg::RSC_PIN && !reset_pin_in && supply_ok)
    |=> q.st == rsc_pkg::RSC_PIN && core_reset)
    else $error("left the pin wait while the pin was low");

  a_pin_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ2
    (q.st == rsc_pkg::RSC_PIN && reset_pin_in && supply_ok)
    |=> q.st == rsc_pkg::RSC_RUN && boot_start)
    else $error("pin high did not release the core");

  // boot start is a single-cycle strobe
  a_boot_once: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ2
    boot_start |=> !boot_start)
    else $error("boot start longer than one cycle");

  // pulse counter steps by one per cycle and releases the pin at the end
  a_pulse_count: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ5
    (q.st == rsc_pkg::RSC_PULSE && q.cnt < PULSE_CYC - 16'h0001 && supply_ok)
    |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("pulse counter skipped");

  a_pulse_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ5
    (q.st == rsc_pkg::RSC_PULSE && q.cnt == PULSE_CYC - 16'h0001 && supply_ok)
    |=> q.st == rsc_pkg::RSC_PIN && !reset_pin_oe)
    else $error("pin not released after the full pulse");

  // any internal request re-arms the one-time key
  a_lock_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ6 RQ17
    (q.st == rsc_pkg::RSC_RUN && int_req && supply_ok)
    |=> !q.lock && q.key == 8'h00)
    else $error("key or lock survived an internal reset");

  a_bad_opcode: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ14
    (q.st == rsc_pkg::RSC_RUN && bad_op && supply_ok)
    |=> q.st == rsc_pkg::RSC_PULSE && q.cause[`RSC_BIT_BADOP])
    else $error("bad opcode did not start a reset");

  a_debug_reset: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ15
    (q.st == rsc_pkg::RSC_RUN && src_req.debug && supply_ok)
    |=> q.st == rsc_pkg::RSC_PULSE && q.cause[`RSC_BIT_DEBUG])
    else $error("debug link request did not start a reset");

  // a fetch that the decoder knows must not disturb the core
  a_valid_code: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ14
    (q.st == rsc_pkg::RSC_RUN && fetch_strobe && (opcode_hit || prebyte_hit)
     && src_req == '0 && !pin_low && supply_ok)
    |=> q.st == rsc_pkg::RSC_RUN)
    else $error("valid code caused a reset");

  // key write: the first one after a reset decides the pin mode
  a_key_take: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ6
    (!q.lock && bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata == 8'hD0
     && q.st == rsc_pkg::RSC_RUN && !int_req && !pin_low && supply_ok)
    |=> gpio_mode && q.lock)
    else $error("output key not taken");

  // anything else stores as zero but still uses up the one write
  a_key_other: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ8
    (!q.lock && bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata != 8'hD0
     && q.st == rsc_pkg::RSC_RUN && !int_req && !pin_low && supply_ok)
    |=> q.key == 8'h00 && q.lock)
    else $error("other key value not stored as zero");

  a_key_late: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ6
    (q.lock && bus_req.wr && bus_req.addr == 8'h00) |=> q.evt[`RSC_EVT_KEY_LATE])
    else $error("late key write not reported");

  // output mode ignores the pin, but an outside pull against a driven high is reported
  a_pin_ignored: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ7
    (gpio_mode && !reset_pin_in && port_a_bit1_output && q.st == rsc_pkg::RSC_RUN
     && !int_req && supply_ok) |=> q.evt[`RSC_EVT_PIN_IGN])
    else $error("ignored pin low not reported");

  // register reads: data one cycle after the strobe, zero otherwise
  a_read_idle: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ8
    !bus_req.rd |=> rd_data == 8'h00)
    else $error("read data outside the read answer cycle");

  a_key_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ8
    (bus_req.rd && bus_req.addr == 8'h00) |=> rd_data == $past(q.key))
    else $error("key register read wrong");

  a_cause_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ12
    (bus_req.rd && bus_req.addr == 8'h01) |=> rd_data == {2'b00, $past(q.cause)})
    else $error("cause register read wrong");

  // a written one clears its flag when no source sets it again
  a_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ10
    (bus_req.wr && bus_req.addr == 8'h01 && !int_req && supply_ok)
    |=> (q.cause & $past(bus_req.wdata[5:0])) == 6'h00)
    else $error("written one did not clear the flag");

  // supply loss is a power-on reset wherever it strikes
  a_supply_loss: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ11 RQ16
    !supply_ok |=> q.st == rsc_pkg::RSC_POR && q.cause == 6'h01 && !q.lock
    && core_reset && !boot_start)
    else $error("supply loss did not restart power-on");

  a_por_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RQ16
    (q.st == rsc_pkg::RSC_POR && supply_ok && q.cnt >= POR_CYC - 16'h0001)
    |=> q.st == rsc_pkg::RSC_RUN && boot_start)
    else $error("power-on hold did not end in time");

endmodule

`default_nettype wire

// *** testbench/rsc_pin_partner.sv ***
/*
  Outside devices sharing the open-drain reset pin, with the weak pull-up.
  Assumes the bench pulses pull_req for one core_clk cycle.
*/
`default_nettype none

module rsc_pin_partner (
  input  wire logic core_clk,
  input  wire logic pull_req,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD_CYC = 38; // 300 ns at 8 ns, rounded up
  int cnt = 0;
  // once asked, hold the line low for the minimum pulse width
  always @(posedge core_clk) begin
    if (pull_req) cnt <= HOLD_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // any low driver wins, pull-up otherwise; contention resolves low
  assign pin_level = !((cnt != 0) || (pin_oe && !pin_out));
endmodule

`default_nettype wire

// *** testbench/reset_source_controller_tb_top.sv ***
/*
  Self-checking bench of the reset source controller.
  Assumes rsc_pkg compiled first and rsc_cfg.svh on the include path.
*/
`default_nettype none

module reset_source_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 0, sys_rst = 1, supply_ok = 1, pull_req = 0, pa1 = 0;
  logic              fetch_strobe = 0, opcode_hit = 0, prebyte_hit = 0;
  rsc_pkg::rsc_bus_t bus = '0;
  rsc_pkg::rsc_src_t src = '0;
  logic [7:0]        rd_data, d;
  logic [15:0]       boot_vector;
  logic              pin_out, pin_oe, pin_lvl, core_reset, boot_start, irq;
  int                num_errors = 0, comparisons = 0, cyc = 0, n;

  rsc_controller #(.POR_HOLD_NS(8)) rsc_controller_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus), .rd_data(rd_data),
    .supply_ok(supply_ok), .src_req(src), .fetch_strobe(fetch_strobe),
    .opcode_hit(opcode_hit), .prebyte_hit(prebyte_hit), .reset_pin_in(pin_lvl),
    .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .port_a_bit1_output(pa1),
    .core_reset(core_reset), .boot_start(boot_start), .boot_vector(boot_vector), .irq(irq));
  rsc_pin_partner rsc_pin_partner_i (
    .core_clk(core_clk), .pull_req(pull_req), .pin_oe(pin_oe), .pin_out(pin_out),
    .pin_level(pin_lvl));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic results;
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk) bus <= '0;
  endtask

  // data stand only in the cycle after the read strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk) bus <= '0;
    #1 v = rd_data;
  endtask

  task automatic wait_boot;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (boot_start !== 1'b1 && n < 4000);
    chk(boot_start, 1'b1, "boot pulse seen");
    chk(core_reset, 1'b0, "released at boot pulse");
    chk(boot_vector, 16'h8000, "boot vector");
  endtask

  // one request; pulse length, release and recorded cause
  task automatic int_reset(input logic [3:0] s, input logic bad, input logic [7:0] exp);
    @(posedge core_clk) src <= rsc_pkg::rsc_src_t'(s);
    fetch_strobe <= bad;
    @(posedge core_clk) src <= '0;
    fetch_strobe <= 1'b0;
    #1 chk({pin_oe, pin_out, core_reset}, 3'b101, "pin driven low");
    n = 0;
    while (pin_oe && !pin_out && n < 3000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n >= 2500 && n < 3000, 1'b1, "low pulse length");
    wait_boot();
    rd(8'h01, d);
    chk(d, exp, "cause flags");
    rd(8'h00, d);
    chk(d, 8'h00, "key back to reset value");
    // clear every flag; reserved bits 7:6 stay zero
    wr(8'h01, 8'h3F);
  endtask

  // hang guard well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      results();
    end
  end

  initial begin
    void'($urandom(35525));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_boot();
    rd(8'h00, d);
    chk(d, 8'h00, "key reset value");
    rd(8'h01, d);
    chk(d, 8'h01, "cause after power-on");
    wr(8'h01, 8'h00);
    rd(8'h01, d);
    chk(d, 8'h01, "zero write keeps flag");
    wr(8'h01, 8'h01);
    rd(8'h01, d);
    chk(d, 8'h00, "one write clears flag");
    d = 8'($urandom);
    if (d == 8'hD0) d = 8'h5A;
    wr(8'h00, d);
    rd(8'h00, d);
    chk(d, 8'h00, "other key stores as zero");
    // valid decodes at random must not reset
    repeat (20) begin
      @(posedge core_clk) fetch_strobe <= 1'b1;
      {opcode_hit, prebyte_hit} <= 2'($urandom_range(1, 3));
      pa1 <= 1'($urandom);
    end
    @(posedge core_clk) fetch_strobe <= 1'b0;
    {opcode_hit, prebyte_hit} <= 2'b00;
    #1 chk(core_reset, 1'b0, "valid code kept running");
    int_reset(4'h8, 1'b0, 8'h20);
    int_reset(4'h4, 1'b0, 8'h10);
    int_reset(4'h2, 1'b0, 8'h08);
    int_reset(4'h1, 1'b0, 8'h02);
    int_reset(4'h0, 1'b1, 8'h04);
    int_reset(4'h9, 1'b0, 8'h22);
    // outside party pulls the pin
    @(posedge core_clk) pull_req <= 1'b1;
    @(posedge core_clk) pull_req <= 1'b0;
    #1 chk(core_reset, 1'b1, "pin reset taken at once");
    wait_boot();
    rd(8'h01, d);
    chk(d, 8'h00, "pin reset sets no cause flag");
    // output mode, once only, with event interrupt
    wr(8'h03, 8'h07);
    wr(8'h00, 8'hD0);
    rd(8'h00, d);
    chk(d, 8'hD0, "key taken");
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk) pa1 <= 1'(v);
      @(posedge core_clk);
      #1 chk({pin_oe, pin_out}, {1'b1, 1'(v)}, "push-pull drive");
    end
    wr(8'h00, 8'h00);
    rd(8'h00, d);
    chk(d, 8'hD0, "second key ignored");
    chk(irq, 1'b1, "irq on events");
    rd(8'h02, d);
    chk(d, 8'h03, "mode and late key events");
    chk(irq, 1'b0, "read clears events");
    wr(8'h03, 8'h00);
    @(posedge core_clk) pull_req <= 1'b1;
    @(posedge core_clk) pull_req <= 1'b0;
    repeat (40) @(posedge core_clk);
    #1 chk(core_reset, 1'b0, "pin ignored in output mode");
    chk(irq, 1'b0, "masked event");
    wr(8'h03, 8'h04);
    #1 chk(irq, 1'b1, "unmasked ignore event");
    rd(8'h02, d);
    chk(d, 8'h04, "ignore event");
    int_reset(4'h4, 1'b0, 8'h10);
    // supply drop acts as power-on
    @(posedge core_clk) supply_ok <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(core_reset, 1'b1, "held while supply low");
    @(posedge core_clk) supply_ok <= 1'b1;
    wait_boot();
    rd(8'h01, d);
    chk(d, 8'h01, "cause after power-down");
    results();
  end
endmodule

`default_nettype wire
